/* File: bench/fbg_board_model.sv */
/*
  Board side of the four pin banks: resolves each line from the block's
  drive and the board's own drive.
  Assumes: bank two in bits 7:0 up to bank five in bits 31:24.
*/
`timescale 1ns/100ps

module fbg_board_model (
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  input wire logic [31:0] boardDrive,
  output logic [31:0] pinLevel
);
  // no pulls: the board always drives a line the block leaves alone
  always_comb begin
    pinLevel = (pinOe & pinOut) | (~pinOe & boardDrive);
  end
endmodule : fbg_board_model

/* File: bench/fbg_gpio_test.sv */
/*
  Self-checking bench for the four bank I/O block: AHB-Lite master tasks,
  random configuration rounds, pin and event checks.
  Assumes: fbg_gpio, fbg_board_model and fbg_consts.svh on the path.
*/
`timescale 1ns/100ps
`include "fbg_consts.svh"

module fbg_gpio_test;
  logic clk_sys, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv, boardDrive, pinLevel;
  wire logic [31:0] pinOut, pinOe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] d, v, iv, m;
  logic [3:0] actM;
  logic [7:0] dirM [4];
  logic [7:0] datM [4];
  logic [7:0] invM [4];
  logic [7:0] dirIdx [4] = '{`FBG_IDX_B2_DIR, `FBG_IDX_B3_DIR, `FBG_IDX_B4_DIR, `FBG_IDX_B5_DIR};
  logic [7:0] datIdx [4] = '{`FBG_IDX_B2_DATA, `FBG_IDX_B3_DATA, `FBG_IDX_B4_DATA,
    `FBG_IDX_B5_DATA};
  logic [7:0] invIdx [4] = '{`FBG_IDX_B2_INV, `FBG_IDX_B3_INV, `FBG_IDX_B4_INV, `FBG_IDX_B5_INV};
  logic [7:0] statIdx [4] = '{`FBG_IDX_B2_STAT, `FBG_IDX_B3_STAT, `FBG_IDX_B4_STAT,
    `FBG_IDX_B5_STAT};
  int n_mismatch, compares, seed;

  fbg_gpio dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .bankTwoPinsIn(pinLevel[7:0]), .bankTwoPinsOut(pinOut[7:0]), .bankTwoPinsOe(pinOe[7:0]),
    .bankThreePinsIn(pinLevel[15:8]), .bankThreePinsOut(pinOut[15:8]),
    .bankThreePinsOe(pinOe[15:8]), .bankFourPinsIn(pinLevel[23:16]),
    .bankFourPinsOut(pinOut[23:16]), .bankFourPinsOe(pinOe[23:16]),
    .bankFivePinsIn(pinLevel[31:24]), .bankFivePinsOut(pinOut[31:24]),
    .bankFivePinsOe(pinOe[31:24]));

  fbg_board_model board (.pinOut(pinOut), .pinOe(pinOe), .boardDrive(boardDrive),
    .pinLevel(pinLevel));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
    // hsel stays up between transfers; htrans alone marks them
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    hsize <= `FBG_HSIZE_WORD;
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    xfer(idx, 1'b1, {24'h000000, wd}, dummy);
  endtask : wr

  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] got;
    xfer(idx, 1'b0, 32'h00000000, got);
    compares++;
    if ({hresp, got} !== {1'b0, 24'h000000, exp}) begin
      n_mismatch++;
      $display("unexpected reg %0h at %0t: got %0h want %0h", idx, $time, {hresp, got},
        {1'b0, 24'h000000, exp});
    end
  endtask : chk_reg

  task automatic chk_pin(input int b, input logic [7:0] exp);
    compares++;
    if (pinLevel[8*b +: 8] !== exp) begin
      n_mismatch++;
      $display("unexpected pins at %0t: got %0h want %0h", $time, pinLevel[8*b +: 8], exp);
    end
  endtask : chk_pin

  // output bits return the register, input bits the pin through inversion
  function automatic logic [7:0] exp_data(input int b);
    return (~dirM[b] & datM[b]) | (dirM[b] & (boardDrive[8*b +: 8] ^ invM[b]));
  endfunction : exp_data

  function automatic logic [7:0] exp_wire(input int b);
    logic [7:0] oe;
    oe = ~dirM[b] & {8{actM[b]}};
    return (oe & (datM[b] ^ invM[b])) | (~oe & boardDrive[8*b +: 8]);
  endfunction : exp_wire

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h87AC;
    n_mismatch = 0;
    compares = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    boardDrive = 32'h00000000;
    actM = 4'h0;
    for (int b = 0; b < 4; b++) begin
      dirM[b] = 8'hFF;
      datM[b] = 8'h00;
      invM[b] = 8'h00;
    end
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_reg(`FBG_IDX_ACT, 8'h00);
    for (int b = 0; b < 4; b++) begin
      chk_reg(dirIdx[b], 8'hFF);
      chk_reg(datIdx[b], 8'h00);
      chk_reg(invIdx[b], 8'h00);
      chk_reg(statIdx[b], 8'h00);
    end
    chk_reg(8'hF3, 8'h00);
    wr(`FBG_IDX_ACT, 8'hFF);
    actM = 4'hF;
    chk_reg(`FBG_IDX_ACT, 8'h0F);
    // edge lands in the very cycle of the clearing read
    boardDrive[7:0] <= 8'hA5;
    @(posedge clk_sys);
    chk_reg(`FBG_IDX_B2_STAT, 8'h00);
    chk_reg(`FBG_IDX_B2_STAT, 8'hA5);
    for (int r = 0; r < 8; r++) begin
      for (int b = 0; b < 4; b++) begin
        boardDrive[8*b +: 8] <= 8'($random(seed));
        // corner rounds: every pin an output, then every pin an input
        d = (r == 0) ? 8'h00 : (r == 1) ? 8'hFF : 8'($random(seed));
        v = 8'($random(seed));
        iv = (r == 1) ? 8'hFF : 8'($random(seed));
        wr(dirIdx[b], d);
        dirM[b] = d;
        wr(datIdx[b], v);
        datM[b] = (datM[b] & d) | (v & ~d);
        wr(invIdx[b], iv);
        invM[b] = iv;
        // config writes move output lines; flush those events first
        repeat (4) @(posedge clk_sys);
        xfer(statIdx[b], 1'b0, 32'h00000000, rdv);
        chk_reg(datIdx[b], exp_data(b));
        chk_pin(b, exp_wire(b));
        m = 8'($random(seed));
        boardDrive[8*b +: 8] <= boardDrive[8*b +: 8] ^ m;
        repeat (5) @(posedge clk_sys);
        chk_reg(statIdx[b], actM[b] ? (m & dirM[b]) : 8'h00);
        wr(statIdx[b], 8'hFF);
        chk_reg(statIdx[b], 8'h00);
        chk_reg(datIdx[b], exp_data(b));
        chk_pin(b, exp_wire(b));
      end
      actM = 4'($random(seed));
      wr(`FBG_IDX_ACT, {4'h0, actM});
      chk_reg(`FBG_IDX_ACT, {4'h0, actM});
    end
    tally_and_finish();
  end
endmodule : fbg_gpio_test

/* File: verilog/fbg_consts.svh */
/*
  Register indices, reset values and bus decode constants for the four
  bank general-purpose I/O block.
  Assumes: included by its bare name; byte address = 4 * index.
*/
`ifndef FBG_CONSTS_SVH
`define FBG_CONSTS_SVH

// register indices
`define FBG_IDX_ACT 8'h30
`define FBG_IDX_B5_DIR 8'hE0
`define FBG_IDX_B5_DATA 8'hE1
`define FBG_IDX_B5_INV 8'hE2
`define FBG_IDX_B2_DIR 8'hE3
`define FBG_IDX_B2_DATA 8'hE4
`define FBG_IDX_B2_INV 8'hE5
`define FBG_IDX_B2_STAT 8'hE6
`define FBG_IDX_B3_STAT 8'hE7
`define FBG_IDX_B4_STAT 8'hE8
`define FBG_IDX_B5_STAT 8'hE9
`define FBG_IDX_B3_DIR 8'hF0
`define FBG_IDX_B3_DATA 8'hF1
`define FBG_IDX_B3_INV 8'hF2
`define FBG_IDX_B4_DIR 8'hF4
`define FBG_IDX_B4_DATA 8'hF5
`define FBG_IDX_B4_INV 8'hF6

// bank numbers inside the block
`define FBG_BANK2 2'h0
`define FBG_BANK3 2'h1
`define FBG_BANK4 2'h2
`define FBG_BANK5 2'h3

// reset values
`define FBG_ACT_RST 4'h0
`define FBG_DIR_RST 8'hFF
`define FBG_DATA_RST 8'h00
`define FBG_INV_RST 8'h00
`define FBG_STAT_RST 8'h00

// bus decode
`define FBG_HSIZE_WORD 3'h2

`endif

/* File: verilog/fbg_gpio.sv */
/*
  Four 8-bit general-purpose I/O banks (two, three, four, five) with
  direction, data, inversion and read-clear edge status registers, reached
  over an AHB-Lite slave port.
  Assumes: single clock clk_sys at 100 MHz, asynchronous active-high rst,
  one AHB-Lite master, word transfers only, pins arrive asynchronously.
*/
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "fbg_consts.svh"

module fbg_gpio #(
  parameter int BANK_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [BANK_W-1:0] bankTwoPinsIn,
  output logic [BANK_W-1:0] bankTwoPinsOut,
  output logic [BANK_W-1:0] bankTwoPinsOe,
  input wire logic [BANK_W-1:0] bankThreePinsIn,
  output logic [BANK_W-1:0] bankThreePinsOut,
  output logic [BANK_W-1:0] bankThreePinsOe,
  input wire logic [BANK_W-1:0] bankFourPinsIn,
  output logic [BANK_W-1:0] bankFourPinsOut,
  output logic [BANK_W-1:0] bankFourPinsOe,
  input wire logic [BANK_W-1:0] bankFivePinsIn,
  output logic [BANK_W-1:0] bankFivePinsOut,
  output logic [BANK_W-1:0] bankFivePinsOe
);

  // bank registers are one byte wide; other widths would break the map
  if (BANK_W != 8) begin : g_bad_width
    $error("fbg_gpio: BANK_W must be 8");
  end

  // every assertion below runs on the bus clock and sleeps through reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  function automatic fbg_pkg::fbg_dec_t mkDec(input fbg_pkg::fbg_kind_t kind,
                                             input logic [1:0] bank);
    fbg_pkg::fbg_dec_t d;
    d.kind = kind;
    d.bank = bank;
    return d;
  endfunction : mkDec

  function automatic fbg_pkg::fbg_dec_t decodeIdx(input logic [7:0] idx);
    fbg_pkg::fbg_dec_t d;
    d = mkDec(fbg_pkg::KIND_NONE, `FBG_BANK2);
    case (idx)
      `FBG_IDX_ACT: d = mkDec(fbg_pkg::KIND_ACT, `FBG_BANK2);
      `FBG_IDX_B5_DIR: d = mkDec(fbg_pkg::KIND_DIR, `FBG_BANK5);
      `FBG_IDX_B5_DATA: d = mkDec(fbg_pkg::KIND_DATA, `FBG_BANK5);
      `FBG_IDX_B5_INV: d = mkDec(fbg_pkg::KIND_INV, `FBG_BANK5);
      `FBG_IDX_B2_DIR: d = mkDec(fbg_pkg::KIND_DIR, `FBG_BANK2);
      `FBG_IDX_B2_DATA: d = mkDec(fbg_pkg::KIND_DATA, `FBG_BANK2);
      `FBG_IDX_B2_INV: d = mkDec(fbg_pkg::KIND_INV, `FBG_BANK2);
      `FBG_IDX_B2_STAT: d = mkDec(fbg_pkg::KIND_STAT, `FBG_BANK2);
      `FBG_IDX_B3_STAT: d = mkDec(fbg_pkg::KIND_STAT, `FBG_BANK3);
      `FBG_IDX_B4_STAT: d = mkDec(fbg_pkg::KIND_STAT, `FBG_BANK4);
      `FBG_IDX_B5_STAT: d = mkDec(fbg_pkg::KIND_STAT, `FBG_BANK5);
      `FBG_IDX_B3_DIR: d = mkDec(fbg_pkg::KIND_DIR, `FBG_BANK3);
      `FBG_IDX_B3_DATA: d = mkDec(fbg_pkg::KIND_DATA, `FBG_BANK3);
      `FBG_IDX_B3_INV: d = mkDec(fbg_pkg::KIND_INV, `FBG_BANK3);
      `FBG_IDX_B4_DIR: d = mkDec(fbg_pkg::KIND_DIR, `FBG_BANK4);
      `FBG_IDX_B4_DATA: d = mkDec(fbg_pkg::KIND_DATA, `FBG_BANK4);
      `FBG_IDX_B4_INV: d = mkDec(fbg_pkg::KIND_INV, `FBG_BANK4);
      default: d = mkDec(fbg_pkg::KIND_NONE, `FBG_BANK2);
    endcase
    return d;
  endfunction : decodeIdx

  // bus state
  fbg_pkg::fbg_bus_state_t busState;
  fbg_pkg::fbg_bus_state_t next_busState;
  logic [7:0] addrIdx;
  logic [7:0] next_addrIdx;
  logic addrOk;
  logic next_addrOk;
  logic [31:0] next_hrdata;
  logic accept;
  logic mapped;
  fbg_pkg::fbg_dec_t dec;
  logic [BANK_W-1:0] rdVal;

  // configuration state
  logic [3:0] actReg;
  logic [3:0] next_actReg;
  logic [3:0][BANK_W-1:0] dirReg;
  logic [3:0][BANK_W-1:0] next_dirReg;
  logic [3:0][BANK_W-1:0] dataReg;
  logic [3:0][BANK_W-1:0] next_dataReg;
  logic [3:0][BANK_W-1:0] invReg;
  logic [3:0][BANK_W-1:0] next_invReg;
  logic [3:0][BANK_W-1:0] pinOut;
  logic [3:0][BANK_W-1:0] next_pinOut;
  logic [3:0][BANK_W-1:0] pinOe;
  logic [3:0][BANK_W-1:0] next_pinOe;

  // pin sampling and events
  logic [3:0][BANK_W-1:0] pinIn;
  logic [3:0][BANK_W-1:0] syncMeta;
  logic [3:0][BANK_W-1:0] syncPin;
  logic [3:0][BANK_W-1:0] prevPin;
  logic [3:0][BANK_W-1:0] next_syncMeta;
  logic [3:0][BANK_W-1:0] next_syncPin;
  logic [3:0][BANK_W-1:0] next_prevPin;
  logic [3:0][BANK_W-1:0] edgeHit;
  logic [3:0][BANK_W-1:0] statClr;
  logic [3:0][BANK_W-1:0] statReg;
  logic [3:0][BANK_W-1:0] next_statReg;

  assign pinIn[0] = bankTwoPinsIn;
  assign pinIn[1] = bankThreePinsIn;
  assign pinIn[2] = bankFourPinsIn;
  assign pinIn[3] = bankFivePinsIn;
  assign bankTwoPinsOut = pinOut[0];
  assign bankThreePinsOut = pinOut[1];
  assign bankFourPinsOut = pinOut[2];
  assign bankFivePinsOut = pinOut[3];
  assign bankTwoPinsOe = pinOe[0];
  assign bankThreePinsOe = pinOe[1];
  assign bankFourPinsOe = pinOe[2];
  assign bankFivePinsOe = pinOe[3];

  // reads take one wait state so that hrdata comes from a flop
  assign hreadyout = (busState != fbg_pkg::BUS_RD1);
  assign hresp = 1'b0;
  assign accept = hsel && htrans[1] && hready;
  // word accesses inside the 1 KiB window only; anything else is ignored
  assign mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                  && (hsize == `FBG_HSIZE_WORD);
  assign dec = addrOk ? decodeIdx(addrIdx) : mkDec(fbg_pkg::KIND_NONE, `FBG_BANK2);

  always_comb begin
    case (dec.kind)
      fbg_pkg::KIND_ACT: rdVal = {4'h0, actReg};
      fbg_pkg::KIND_DIR: rdVal = dirReg[dec.bank];
      // output bits show the register, input bits the sampled pin through inversion
      fbg_pkg::KIND_DATA: rdVal = (dataReg[dec.bank] & ~dirReg[dec.bank])
        | ((syncPin[dec.bank] ^ invReg[dec.bank]) & dirReg[dec.bank]);
      fbg_pkg::KIND_INV: rdVal = invReg[dec.bank];
      fbg_pkg::KIND_STAT: rdVal = statReg[dec.bank];
      default: rdVal = 8'h00;
    endcase
  end

  always_comb begin
    next_busState = busState;
    next_addrIdx = addrIdx;
    next_addrOk = addrOk;
    next_hrdata = hrdata;
    case (busState)
      fbg_pkg::BUS_RD1: begin
        next_hrdata = {24'h000000, rdVal};
        next_busState = fbg_pkg::BUS_RD2;
      end
      default: begin
        if (accept) begin
          next_addrIdx = haddr[9:2];
          next_addrOk = mapped;
          next_busState = hwrite ? fbg_pkg::BUS_WR : fbg_pkg::BUS_RD1;
        end else begin
          next_busState = fbg_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busState <= fbg_pkg::BUS_IDLE;
      addrIdx <= 8'h00;
      addrOk <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      busState <= next_busState;
      addrIdx <= next_addrIdx;
      addrOk <= next_addrOk;
      hrdata <= next_hrdata;
    end
  end

  always_comb begin
    next_actReg = actReg;
    next_dirReg = dirReg;
    next_dataReg = dataReg;
    next_invReg = invReg;
    if (busState == fbg_pkg::BUS_WR) begin
      case (dec.kind)
        fbg_pkg::KIND_ACT: next_actReg = hwdata[3:0];
        fbg_pkg::KIND_DIR: next_dirReg[dec.bank] = hwdata[7:0];
        fbg_pkg::KIND_DATA: next_dataReg[dec.bank] = (dataReg[dec.bank] & dirReg[dec.bank])
          | (hwdata[7:0] & ~dirReg[dec.bank]);
        fbg_pkg::KIND_INV: next_invReg[dec.bank] = hwdata[7:0];
        default: next_actReg = actReg;
      endcase
    end
    for (int b = 0; b < 4; b++) begin
      // pin flops load together with the registers: no extra latency
      next_pinOut[b] = next_dataReg[b] ^ next_invReg[b];
      next_pinOe[b] = ~next_dirReg[b] & {BANK_W{next_actReg[b]}};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      actReg <= `FBG_ACT_RST;
      dirReg <= {4{`FBG_DIR_RST}};
      dataReg <= {4{`FBG_DATA_RST}};
      invReg <= {4{`FBG_INV_RST}};
      pinOut <= {4{8'h00}};
      pinOe <= {4{8'h00}};
    end else begin
      actReg <= next_actReg;
      dirReg <= next_dirReg;
      dataReg <= next_dataReg;
      invReg <= next_invReg;
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
    end
  end

  always_comb begin
    next_syncMeta = pinIn;
    next_syncPin = syncMeta;
    next_prevPin = syncPin;
    for (int b = 0; b < 4; b++) begin
      // inactive banks record no events; also hides the reset-time step
      edgeHit[b] = (syncPin[b] ^ prevPin[b]) & {BANK_W{actReg[b]}};
      statClr[b] = (busState == fbg_pkg::BUS_RD1 && dec.kind == fbg_pkg::KIND_STAT
                    && dec.bank == 2'(b)) ? 8'hFF : 8'h00;
      // set after clear, so an edge during the read survives
      next_statReg[b] = (statReg[b] & ~statClr[b]) | edgeHit[b];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncMeta <= {4{8'h00}};
      syncPin <= {4{8'h00}};
      prevPin <= {4{8'h00}};
      statReg <= {4{`FBG_STAT_RST}};
    end else begin
      syncMeta <= next_syncMeta;
      syncPin <= next_syncPin;
      prevPin <= next_prevPin;
      statReg <= next_statReg;
    end
  end

  sequence s_wr(logic [7:0] idx);
    busState == fbg_pkg::BUS_WR && addrOk && addrIdx == idx;
  endsequence

  sequence s_rd(logic [7:0] idx);
    busState == fbg_pkg::BUS_RD1 && addrOk && addrIdx == idx;
  endsequence

  sequence s_rd_accept;
    accept && !hwrite && busState != fbg_pkg::BUS_RD1;
  endsequence

  a_reset_dir_ones: assert property (
    $past(rst) |-> dirReg == {4{8'hFF}} && pinOe == {4{8'h00}})
    else $error("direction not all ones after reset");

  a_reset_data_zero: assert property (
    $past(rst) |-> dataReg == {4{8'h00}} && invReg == {4{8'h00}})
    else $error("data or inversion not zero after reset");

  a_act_gates_oe: assert property (
    s_wr(`FBG_IDX_ACT) ##0 !hwdata[0] |=> bankTwoPinsOe == 8'h00)
    else $error("inactive bank still drives");

  a_dir_sets_oe: assert property (
    s_wr(`FBG_IDX_B2_DIR) ##0 actReg[0]
    |=> bankTwoPinsOe == ~$past(hwdata[7:0]))
    else $error("output enable does not follow direction");

  a_data_drives_pin: assert property (
    s_wr(`FBG_IDX_B2_DATA) ##0 (dirReg[0] == 8'h00 && invReg[0] == 8'h00)
    |=> bankTwoPinsOut == $past(hwdata[7:0]))
    else $error("written data not driven");

  a_input_write_ignored: assert property (
    s_wr(`FBG_IDX_B2_DATA) ##0 dirReg[0] == 8'hFF |=> $stable(dataReg[0]))
    else $error("write to input bits took effect");

  a_inverted_readback: assert property (
    s_rd(`FBG_IDX_B2_DATA) ##0 (dirReg[0] == 8'hFF && invReg[0] == 8'hFF)
    |=> hrdata[7:0] == ~$past(bankTwoPinsIn, 3))
    else $error("inverted input readback wrong");

  a_edge_sets_status: assert property (
    (actReg[0] && syncPin[0] != prevPin[0])
    |=> (statReg[0] & $past(syncPin[0] ^ prevPin[0])) == $past(syncPin[0] ^ prevPin[0]))
    else $error("edge not recorded");

  a_read_clears: assert property (
    s_rd(`FBG_IDX_B2_STAT) ##0 edgeHit[0] == 8'h00
    |=> statReg[0] == 8'h00 ##0 hrdata[7:0] == $past(statReg[0]))
    else $error("status read did not return and clear");

  a_edge_beats_clear: assert property (
    s_rd(`FBG_IDX_B2_STAT) ##0 edgeHit[0] != 8'h00
    |=> statReg[0] == $past(edgeHit[0]))
    else $error("edge lost in clearing read");

  a_read_wait: assert property (
    s_rd_accept |=> !hreadyout ##1 hreadyout)
    else $error("read not answered after one wait state");

  a_write_no_wait: assert property (
    accept && hwrite |=> hreadyout)
    else $error("write data phase stalled");

  // bank two stands in for all four in the checks below
  a_sync_depth: assert property (
    !$past(rst) && !$past(rst, 2) |-> syncPin[0] == $past(bankTwoPinsIn, 2))
    else $error("pin sample not two stages behind the pin");

  a_input_not_driven: assert property (
    (bankTwoPinsOe & dirReg[0]) == 8'h00)
    else $error("input pin driven by the block");

  a_set_needs_edge: assert property (
    1'b1 |=> (statReg[0] & ~$past(statReg[0]) & ~$past(syncPin[0] ^ prevPin[0])) == 8'h00)
    else $error("status bit set without an edge");

  a_idle_no_event: assert property (
    !actReg[0] |=> (statReg[0] & ~$past(statReg[0])) == 8'h00)
    else $error("inactive bank recorded an event");

  a_stat_held: assert property (
    statClr[0] == 8'h00 |=> (statReg[0] & $past(statReg[0])) == $past(statReg[0]))
    else $error("status bit dropped without a read");

  a_act_upper_zero: assert property (
    s_rd(`FBG_IDX_ACT) |=> hrdata[31:4] == 28'h0000000)
    else $error("activation read shows reserved bits");

  a_unmapped_zero: assert property (
    busState == fbg_pkg::BUS_RD1 && dec.kind == fbg_pkg::KIND_NONE
    |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : fbg_gpio

/* File: verilog/fbg_pkg.sv */
/*
  Types shared by the four bank general-purpose I/O block.
  Assumes: nothing beyond a SystemVerilog compiler.
*/
package fbg_pkg;

  typedef enum {BUS_IDLE, BUS_WR, BUS_RD1, BUS_RD2} fbg_bus_state_t;

  typedef enum logic [2:0] {KIND_NONE, KIND_ACT, KIND_DIR, KIND_DATA, KIND_INV,
    KIND_STAT} fbg_kind_t;

  typedef struct packed {
    fbg_kind_t kind;
    logic [1:0] bank;
  } fbg_dec_t;

endpackage : fbg_pkg
